// ---- common/frr_pkg.sv ----
// Constants and types shared by the fault record and restart controller
//
// Notes on behaviour
// R1 - With arm set, a fault copies fault flags and ADC bytes into EEPROM.
// R2 - Internal logic never clears the arm bit; only a host write does.
// R3 - Host clears of started and done flags take effect only while unlock is 1.
// R4 - Started flag set when a record begins; host 1 ignored, host 0 clears.
// R5 - Done flag set when a record finishes; host may clear, never set.
// R6 - Alert enable 1 gives an alert on record completion; 0 gives none.
// R7 - Reserved bits read zero: control bits 2:0, restart bits 3:2.
// R8 - Fault byte goes to EEPROM 0xA4, five alarm log bytes to 0xA5-0xA9.
// R9 - Latest sense-current MSB goes to EEPROM 0xE1.
// R10 - Lowest and highest sense-current MSBs go to EEPROM 0xE2 and 0xE3.
// R11 - Latest, lowest, highest supply MSBs go to EEPROM 0xE4-0xE6.
// R12 - Enable set plus restart command restarts after delay; enable stays set.
// R13 - Host clears the restart enable before each later restart command.
// R14 - Delay select codes 0-7 give 0.512 s doubling up to 65.5 s.
// R15 - Status bit 1 reads 1 during restart or cooling delay, or latch-off.
// R16 - Status bit 0 mirrors the write-protect pin level.
// R17 - A new record starts only with arm set and started clear.
// R18 - Restart delay comes from a base prescaler times a power of two.
package frr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_REC_CTRL = 8'h90;
  localparam logic [7:0] ADDR_RESTART = 8'hA2;
  localparam logic [7:0] REC_CTRL_RESET = 8'h00;
  localparam logic [7:0] RESTART_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Record control fields
  localparam int REC_ARM_BIT = 7;
  localparam int REC_UNLOCK_BIT = 6;
  localparam int REC_STARTED_BIT = 5;
  localparam int REC_DONE_BIT = 4;
  localparam int REC_ALERT_EN_BIT = 3;

  // Restart control fields
  localparam int RST_EN_BIT = 7;
  localparam int RST_SEL_HI = 6;
  localparam int RST_SEL_LO = 4;
  localparam int RST_SEL_W = 3;
  localparam int RST_STATUS_BIT = 1;
  localparam int RST_WP_BIT = 0;

  ////////////////////////////////////////////////////////////////////////
  // Record layout
  localparam int LOG_BYTES = 6;
  localparam int ADC_BYTES = 6;
  localparam int REC_BYTES = LOG_BYTES + ADC_BYTES;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] LOG_BYTES_IDX = 4'h6;
  localparam logic [IDX_W-1:0] LAST_IDX = 4'hB;
  localparam logic [7:0] EE_LOG_BASE = 8'hA4;
  localparam logic [7:0] EE_ADC_BASE = 8'hE1;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESTART_BASE_MS = 512;
  localparam int RESTART_BASE_CYCLES = RESTART_BASE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BASE_CNT_W = 24;
  localparam int TICK_CNT_W = 8;

  typedef enum logic [1:0] {
    FRR_IDLE,
    FRR_WRITE,
    FRR_FINISH
  } frr_rec_state_t;

endpackage

// ---- common/frr_tmr_if.sv ----
// Link between the controller and its restart delay timer
`timescale 1ns/10ps
interface frr_tmr_if;
  logic start;
  logic [frr_pkg::RST_SEL_W-1:0] sel;
  logic busy;
  logic expire;
  modport ctrl (output start, output sel, input busy, input expire);
  modport timer (input start, input sel, output busy, output expire);
endinterface

// ---- rtl/frr_delay_timer.sv ----
// Restart delay timer: base prescaler times a power-of-two tick count
`timescale 1ns/10ps
module frr_delay_timer #(
  parameter int BASE_CYCLES = frr_pkg::RESTART_BASE_CYCLES
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Controller side
  frr_tmr_if.timer tmr
);
  import frr_pkg::*;

  typedef struct packed {
    logic busy;
    logic expire;
    logic [BASE_CNT_W-1:0] base_cnt;
    logic [TICK_CNT_W-1:0] ticks;
    logic [TICK_CNT_W-1:0] limit;
  } frr_tmr_state_t;

  frr_tmr_state_t s_r;
  frr_tmr_state_t s_nxt;

  function automatic logic [TICK_CNT_W-1:0] tick_limit(input logic [RST_SEL_W-1:0] sel);
    tick_limit = TICK_CNT_W'((1 << sel) - 1);
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.expire = 1'b0;
    if (!s_r.busy) begin
      if (tmr.start) begin
        s_nxt.busy = 1'b1;
        s_nxt.base_cnt = '0;
        s_nxt.ticks = '0;
        // R18 power-of-two multiple
        s_nxt.limit = tick_limit(tmr.sel);
      end
    end else if (s_r.base_cnt == BASE_CNT_W'(BASE_CYCLES - 1)) begin
      s_nxt.base_cnt = '0;
      // R14 delay reached
      if (s_r.ticks == s_r.limit) begin
        s_nxt.busy = 1'b0;
        s_nxt.expire = 1'b1;
      end else begin
        s_nxt.ticks = s_r.ticks + 1'b1;
      end
    end else begin
      s_nxt.base_cnt = s_r.base_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign tmr.busy = s_r.busy;
  assign tmr.expire = s_r.expire;

endmodule

// ---- rtl/frr_top.sv ----
// Fault record sequencer, restart control and their host registers
`timescale 1ns/10ps
module frr_top #(
  parameter int BASE_CYCLES = frr_pkg::RESTART_BASE_CYCLES
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,

  // Host register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,

  // Fault trigger and captured sources
  input wire logic fault_event,
  input wire logic [7:0] sys_fault_byte,
  input wire logic [frr_pkg::LOG_BYTES-2:0][7:0] alarm_log,
  input wire logic [7:0] sense_reading_latest,
  input wire logic [7:0] sense_reading_lowest,
  input wire logic [7:0] sense_reading_highest,
  input wire logic [7:0] supply_reading_latest,
  input wire logic [7:0] supply_reading_lowest,
  input wire logic [7:0] supply_reading_highest,

  // EEPROM write port
  output logic ee_wr_req,
  output logic [7:0] ee_wr_addr,
  output logic [7:0] ee_wr_data,
  input wire logic ee_wr_ack,

  // Record status
  output logic record_alert,
  output logic record_busy,

  // Restart control
  input wire logic restart_cmd,
  input wire logic cooling_delay_active,
  input wire logic latched_off,
  input wire logic write_protect_pin,
  output logic restart_out
);
  import frr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    // Record control register
    logic rec_arm;
    logic rec_unlock;
    logic rec_started;
    logic rec_done;
    logic rec_alert_en;
    // Restart control register
    logic auto_restart_enable;
    logic [RST_SEL_W-1:0] restart_delay_select;
    // Sequencer
    frr_rec_state_t rec_state;
    logic [IDX_W-1:0] idx;
    logic [REC_BYTES-1:0][7:0] snap;
    // Outputs
    logic ee_req;
    logic [7:0] ee_addr;
    logic [7:0] ee_data;
    logic [7:0] rdata;
    logic rdata_valid;
    logic alert;
    logic busy;
    logic restart_pulse;
  } frr_state_t;

  frr_state_t s_r;
  frr_state_t s_nxt;

  frr_tmr_if tmr ();

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // EEPROM location of record byte idx: log bytes first, then ADC bytes
  function automatic logic [7:0] ee_map(input logic [IDX_W-1:0] idx);
    logic [7:0] ofs;
    ofs = 8'h00;
    if (idx < LOG_BYTES_IDX) begin
      ofs = {4'h0, idx};
      ee_map = EE_LOG_BASE + ofs;
    end else begin
      ofs = {4'h0, idx - LOG_BYTES_IDX};
      ee_map = EE_ADC_BASE + ofs;
    end
  endfunction

  // Record image in write order
  function automatic logic [REC_BYTES-1:0][7:0] take_snapshot(
    input logic [7:0] fb,
    input logic [LOG_BYTES-2:0][7:0] al,
    input logic [ADC_BYTES-1:0][7:0] adc
  );
    logic [REC_BYTES-1:0][7:0] img;
    img = '0;
    img[0] = fb;
    for (int i = 0; i < LOG_BYTES - 1; i++) begin
      img[i + 1] = al[i];
    end
    for (int i = 0; i < ADC_BYTES; i++) begin
      img[LOG_BYTES + i] = adc[i];
    end
    take_snapshot = img;
  endfunction

  function automatic logic [7:0] rec_ctrl_view(input frr_state_t s);
    logic [7:0] v;
    // R7 reserved bits zero
    v = 8'h00;
    v[REC_ARM_BIT] = s.rec_arm;
    v[REC_UNLOCK_BIT] = s.rec_unlock;
    v[REC_STARTED_BIT] = s.rec_started;
    v[REC_DONE_BIT] = s.rec_done;
    v[REC_ALERT_EN_BIT] = s.rec_alert_en;
    rec_ctrl_view = v;
  endfunction

  // Restart register image; status and pin level are live, not stored
  function automatic logic [7:0] restart_view(
    input frr_state_t s,
    input logic status,
    input logic wp
  );
    logic [7:0] v;
    // R7 reserved bits zero
    v = 8'h00;
    v[RST_EN_BIT] = s.auto_restart_enable;
    v[RST_SEL_HI:RST_SEL_LO] = s.restart_delay_select;
    // R15 delay status
    v[RST_STATUS_BIT] = status;
    // R16 write-protect level
    v[RST_WP_BIT] = wp;
    restart_view = v;
  endfunction

  // Address match shared by write and read decode
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_ofs);
    addr_hit = (a == reg_ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  logic [ADC_BYTES-1:0][7:0] adc_bytes;
  logic rec_wr;
  logic rst_wr;
  logic delay_active;

  // Order sets EEPROM locations E1..E6
  assign adc_bytes = {supply_reading_highest, supply_reading_lowest, supply_reading_latest,
                      sense_reading_highest, sense_reading_lowest, sense_reading_latest};
  assign rec_wr = reg_wr && addr_hit(reg_addr, ADDR_REC_CTRL);
  assign rst_wr = reg_wr && addr_hit(reg_addr, ADDR_RESTART);
  // R15 any delay or latch-off
  assign delay_active = tmr.busy || cooling_delay_active || latched_off;

  // R12 start restart delay
  assign tmr.start = restart_cmd && s_r.auto_restart_enable;
  assign tmr.sel = s_r.restart_delay_select;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata_valid = 1'b0;
    s_nxt.alert = 1'b0;
    s_nxt.restart_pulse = tmr.expire;

    // Host writes first, so hardware sets below win in the same cycle
    if (rec_wr) begin
      // R2 only the host changes arm
      s_nxt.rec_arm = reg_wdata[REC_ARM_BIT];
      s_nxt.rec_unlock = reg_wdata[REC_UNLOCK_BIT];
      s_nxt.rec_alert_en = reg_wdata[REC_ALERT_EN_BIT];
      // R3 clears gated by unlock
      if (s_r.rec_unlock) begin
        // R4 write 0 clears, 1 ignored
        if (!reg_wdata[REC_STARTED_BIT]) begin
          s_nxt.rec_started = 1'b0;
        end
        // R5 host can only clear
        if (!reg_wdata[REC_DONE_BIT]) begin
          s_nxt.rec_done = 1'b0;
        end
      end
    end

    if (rst_wr) begin
      // R12 enable kept until host clears
      s_nxt.auto_restart_enable = reg_wdata[RST_EN_BIT];
      // R14 delay code
      s_nxt.restart_delay_select = reg_wdata[RST_SEL_HI:RST_SEL_LO];
    end

    // Record sequencer
    case (s_r.rec_state)
      FRR_IDLE: begin
        // R17 one record until the host clears started
        if (fault_event && s_r.rec_arm && !s_r.rec_started) begin
          // R4 record begins
          s_nxt.rec_started = 1'b1;
          // R1 freeze sources at the fault
          s_nxt.snap = take_snapshot(sys_fault_byte, alarm_log, adc_bytes);
          s_nxt.idx = '0;
          s_nxt.busy = 1'b1;
          s_nxt.rec_state = FRR_WRITE;
        end
      end
      FRR_WRITE: begin
        if (!s_r.ee_req) begin
          // R8 R9 R10 R11 location per byte
          s_nxt.ee_req = 1'b1;
          s_nxt.ee_addr = ee_map(s_r.idx);
          s_nxt.ee_data = s_r.snap[s_r.idx];
        end else if (ee_wr_ack) begin
          s_nxt.ee_req = 1'b0;
          if (s_r.idx == LAST_IDX) begin
            s_nxt.rec_state = FRR_FINISH;
          end else begin
            s_nxt.idx = s_r.idx + 1'b1;
          end
        end
      end
      FRR_FINISH: begin
        // R5 record done
        s_nxt.rec_done = 1'b1;
        // R6 alert only when enabled
        s_nxt.alert = s_r.rec_alert_en;
        s_nxt.busy = 1'b0;
        s_nxt.rec_state = FRR_IDLE;
      end
      default: begin
        s_nxt.ee_req = 1'b0;
        s_nxt.busy = 1'b0;
        s_nxt.rec_state = FRR_IDLE;
      end
    endcase

    // Read sees register values before this cycle's write
    if (reg_rd) begin
      s_nxt.rdata_valid = 1'b1;
      if (addr_hit(reg_addr, ADDR_REC_CTRL)) begin
        s_nxt.rdata = rec_ctrl_view(s_r);
      end else if (addr_hit(reg_addr, ADDR_RESTART)) begin
        s_nxt.rdata = restart_view(s_r, delay_active, write_protect_pin);
      end else begin
        s_nxt.rdata = UNMAPPED_READ;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.rec_arm <= REC_CTRL_RESET[REC_ARM_BIT];
      s_r.rec_unlock <= REC_CTRL_RESET[REC_UNLOCK_BIT];
      s_r.rec_started <= REC_CTRL_RESET[REC_STARTED_BIT];
      s_r.rec_done <= REC_CTRL_RESET[REC_DONE_BIT];
      s_r.rec_alert_en <= REC_CTRL_RESET[REC_ALERT_EN_BIT];
      s_r.auto_restart_enable <= RESTART_RESET[RST_EN_BIT];
      s_r.restart_delay_select <= RESTART_RESET[RST_SEL_HI:RST_SEL_LO];
      s_r.rec_state <= FRR_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Restart delay timer

  // Long count kept as a parameter so simulation can shorten it
  frr_delay_timer #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .tmr(tmr.timer)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = s_r.rdata;
  assign reg_rdata_valid = s_r.rdata_valid;
  assign ee_wr_req = s_r.ee_req;
  assign ee_wr_addr = s_r.ee_addr;
  assign ee_wr_data = s_r.ee_data;
  assign record_alert = s_r.alert;
  assign record_busy = s_r.busy;
  assign restart_out = s_r.restart_pulse;

endmodule

// ---- verification/frr_ee_model.sv ----
// EEPROM write responder with a programmable acknowledge lag
`timescale 1ns/10ps
module frr_ee_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Write port
  input wire logic ee_wr_req,
  input wire logic [7:0] ee_wr_addr,
  input wire logic [7:0] ee_wr_data,
  input wire logic [2:0] lag,
  output logic ee_wr_ack
);
  logic [7:0] mem [256];
  logic [2:0] cnt;
  int n_wr = 0;
  // Slow acks stall the sequencer between bytes
  always @(posedge sys_clk) begin
    ee_wr_ack <= 1'b0;
    if (rst) begin
      cnt <= 3'h0;
    end else if (ee_wr_req && !ee_wr_ack) begin
      if (cnt == lag) begin
        ee_wr_ack <= 1'b1;
        mem[ee_wr_addr] <= ee_wr_data;
        n_wr <= n_wr + 1;
        cnt <= 3'h0;
      end else begin
        cnt <= cnt + 3'h1;
      end
    end
  end
endmodule

// ---- verification/frr_props.sv ----
// Port checker for the fault record and restart controller
`timescale 1ns/10ps
module frr_props (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid,
  // Record side
  input wire logic ee_wr_req,
  input wire logic [7:0] ee_wr_addr,
  input wire logic [7:0] ee_wr_data,
  input wire logic ee_wr_ack,
  input wire logic record_alert,
  input wire logic record_busy,
  // Restart side
  input wire logic cooling_delay_active,
  input wire logic latched_off,
  input wire logic write_protect_pin,
  input wire logic restart_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence rd_of(a);
    ce && reg_rd && reg_addr == a;
  endsequence
  sequence rec_begin;
    $rose(record_busy);
  endsequence
  sequence first_wr;
    ee_wr_req && ee_wr_addr == 8'hA4;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  read_valid_a: assert property (ce && reg_rd |=> reg_rdata_valid)
    else $error("read not answered");
  unmapped_zero_a: assert property (ce && reg_rd && reg_addr != 8'h90 && reg_addr != 8'hA2 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  ctl_reserved_a: assert property (rd_of(8'h90) |=> reg_rdata[2:0] == 3'h0)
    else $error("control reserved bits set");
  wp_status_a: assert property (rd_of(8'hA2) |=> reg_rdata[3:2] == 2'h0 && reg_rdata[0] == $past(write_protect_pin))
    else $error("restart register status wrong");
  delay_status_a: assert property (rd_of(8'hA2) ##0 (latched_off || cooling_delay_active) |=> reg_rdata[1])
    else $error("delay status low");
  first_byte_a: assert property (rec_begin |-> ##1 first_wr)
    else $error("record does not open at first fault byte");
  req_hold_a: assert property (ee_wr_req && !ee_wr_ack |=> ee_wr_req && $stable(ee_wr_addr) && $stable(ee_wr_data))
    else $error("eeprom request dropped or changed");
  req_drop_a: assert property (ee_wr_req && ee_wr_ack |=> !ee_wr_req)
    else $error("eeprom request held after ack");
  req_busy_a: assert property (ee_wr_req |-> record_busy)
    else $error("eeprom write outside a record");
  alert_end_a: assert property (record_alert |-> $fell(record_busy) ##1 !record_alert)
    else $error("alert not a single pulse at record end");
  restart_pulse_a: assert property (restart_out |=> !restart_out)
    else $error("restart pulse too long");
endmodule
bind frr_top frr_props CHK (.*);

// ---- verification/tb_top.sv ----
// Self-checking bench for the fault record and restart controller
`timescale 1ns/10ps
module tb_top;
  import frr_pkg::*;
  localparam int BASE = 8;
  logic sys_clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, fault_event = 0;
  logic restart_cmd = 0, cool = 0, latch = 0, wp = 0, rdv, ee_req, ee_ack, alert, busy, r_out;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, fb = 8'h00, rdata, ee_addr, ee_data;
  logic [4:0][7:0] al = '0;
  logic [5:0][7:0] adc = '0;
  logic [2:0] lag = 3'h0;
  logic [31:0] seed = 32'h00015032;
  int error_cnt = 0, n_checks = 0, alerts = 0, cyc = 0, n, w, s;

  frr_top #(.BASE_CYCLES(BASE)) DUT (.sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rdata_valid(rdv),
    .fault_event(fault_event), .sys_fault_byte(fb), .alarm_log(al), .sense_reading_latest(adc[0]),
    .sense_reading_lowest(adc[1]), .sense_reading_highest(adc[2]), .supply_reading_latest(adc[3]),
    .supply_reading_lowest(adc[4]), .supply_reading_highest(adc[5]), .ee_wr_req(ee_req),
    .ee_wr_addr(ee_addr), .ee_wr_data(ee_data), .ee_wr_ack(ee_ack), .record_alert(alert),
    .record_busy(busy), .restart_cmd(restart_cmd), .cooling_delay_active(cool), .latched_off(latch),
    .write_protect_pin(wp), .restart_out(r_out));
  frr_ee_model EE (.sys_clk(sys_clk), .rst(rst), .ee_wr_req(ee_req), .ee_wr_addr(ee_addr),
    .ee_wr_data(ee_data), .lag(lag), .ee_wr_ack(ee_ack));

  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (alert) alerts++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("ERROR %0t run did not finish", $time);
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function logic [7:0] rv();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function logic [7:0] ee_a(int i);
    return i < 6 ? 8'hA4 + 8'(i) : 8'hE1 + 8'(i - 6);
  endfunction
  function logic [7:0] exp_d(int i);
    return i == 0 ? fb : (i < 6 ? al[i-1] : adc[i-6]);
  endfunction
  task chk(logic [7:0] g, logic [7:0] e, string m);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task chkn(int g, int e, string m);
    n_checks++;
    if (g != e) begin
      error_cnt++;
      $display("ERROR %0t %s got %0d exp %0d", $time, m, g, e);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task rdc(logic [7:0] a, logic [7:0] e, string m);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 chk(rdata, e, m);
  endtask
  task pulse_fault();
    @(posedge sys_clk);
    fault_event <= 1;
    @(posedge sys_clk);
    fault_event <= 0;
  endtask
  // Fresh sources and ack lag, then wait for the record to close
  task rec_run();
    logic seen;
    seen = 0;
    @(posedge sys_clk);
    fb <= rv();
    lag <= 3'(rv());
    for (int i = 0; i < 5; i++) al[i] <= rv();
    for (int i = 0; i < 6; i++) adc[i] <= rv();
    pulse_fault();
    for (int i = 0; i < 600 && !(seen && !busy); i++) begin
      @(posedge sys_clk);
      #1 seen |= busy;
    end
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 12; i++) chk(EE.mem[ee_a(i)], exp_d(i), "record byte");
    $display("record test done");
  endtask
  task kick(output int c);
    @(posedge sys_clk);
    restart_cmd <= 1;
    @(posedge sys_clk);
    restart_cmd <= 0;
    c = 0;
    do begin
      @(posedge sys_clk);
      #1 c++;
    end while (!r_out && c < 1100);
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    wp <= 1;
    rdc(8'h90, 8'h00, "control reset");
    rdc(8'hA2, 8'h01, "restart reset");
    wr(8'h55, 8'hFF);
    rdc(8'h55, 8'h00, "unmapped");
    wr(8'h90, 8'hFF);
    rdc(8'h90, 8'hC8, "host sets flags");
    rec_run();
    chkn(alerts, 1, "alert enabled");
    rdc(8'h90, 8'hF8, "after record");
    w = EE.n_wr;
    pulse_fault();
    repeat (30) @(posedge sys_clk);
    chkn(EE.n_wr, w, "started blocks record");
    wr(8'h90, 8'h80);
    rdc(8'h90, 8'h80, "unlocked clear");
    rec_run();
    chkn(alerts, 1, "alert disabled");
    wr(8'h90, 8'h80);
    rdc(8'h90, 8'hB0, "locked clear");
    wr(8'h90, 8'h40);
    rdc(8'h90, 8'h70, "host clears arm");
    wr(8'h90, 8'h00);
    rdc(8'h90, 8'h00, "disarmed flags clear");
    w = EE.n_wr;
    pulse_fault();
    repeat (30) @(posedge sys_clk);
    chkn(EE.n_wr, w, "disarmed");
    $display("control test done");
    for (s = 0; s < 8; s++) begin
      wr(8'hA2, 8'h80 | 8'(s << 4));
      kick(n);
      chkn(n, BASE * (1 << s) + 1, "restart delay");
      rdc(8'hA2, 8'h81 | 8'(s << 4), "enable kept");
      wr(8'hA2, 8'h00);
    end
    kick(n);
    chkn(n, 1100, "restart disabled");
    wr(8'hA2, 8'h80);
    @(posedge sys_clk);
    restart_cmd <= 1;
    @(posedge sys_clk);
    restart_cmd <= 0;
    rdc(8'hA2, 8'h83, "delay running");
    for (int i = 0; i < 50 && !r_out; i++) @(posedge sys_clk);
    latch <= 1;
    rdc(8'hA2, 8'h83, "latched off");
    latch <= 0;
    cool <= 1;
    rdc(8'hA2, 8'h83, "cooling");
    cool <= 0;
    wp <= 0;
    rdc(8'hA2, 8'h80, "idle wp low");
    $display("restart test done");
    wrap_up();
  end
endmodule
